// file: src/flash_self_program_sequencer.sv
// Purpose: Run-time self-programming sequencer for on-chip program flash
// Assumes: APB from the core, table instruction port, flash array logic on pclk
// Notes: Core and APB are stalled while an erase or program runs
// Overview of operation
// - Erase one 32-instruction row, program four instructions
// - Low table access reaches word bits 15:0
// - High table access reaches word bits 23:16
// - Address is page low byte plus EA
// - Panels of 128 rows; software moves page
// - Four write latches, chosen by EA bits 2:1
// - Table write touches latches only, two cycles
// - Low address captures EA 15:0
// - Upper address captures the page
// - Write-only key needs 0x55 then 0xAA
// - Start bit 15 cleared when operation ends
// - Operation lasts 2 ms, core stalled
// - Control selects operation, write enable and start
`timescale 1ns/1ps
`include "flash_seq_defines.svh"
module flash_self_program_sequencer #(
   parameter int unsigned OP_CYCLES = `FS_OP_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Table instruction port
   input wire logic tbl_req,
   input wire logic tbl_write,
   input wire logic tbl_high,
   input wire logic tbl_byte,
   input wire logic [15:0] tbl_ea,
   input wire logic [15:0] tbl_wdata,
   output logic tbl_done,
   output logic [15:0] tbl_rdata,
   // Flash array
   output logic [23:0] flash_rd_addr,
   input wire logic [23:0] flash_rd_data,
   output logic flash_erase,
   output logic flash_program,
   output logic [23:0] flash_op_addr,
   output flash_seq_pkg::latch_words_t flash_prog_data,
   output logic cpu_stall
);
   import flash_seq_pkg::*;

   logic [7:0] page_q;
   logic [15:0] addr_low_q;
   logic [7:0] addr_upper_q;
   logic [7:0] op_q;
   logic erase_program_enable_q, wr_q, err_q, busy_q;
   logic [31:0] cnt_q;
   key_state_e key_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [1:0] tph_q;
   logic t_write_q, t_high_q, t_byte_q;
   logic [15:0] t_ea_q, tbl_rdata_q;
   logic [23:0] rd_addr_q, op_addr_q;
   logic erase_q, program_q;
   logic wr_acc, tbl_take, start_req, start_ok, op_ok, op_last;
   localparam logic [15:0] CTRL_RESET = `FS_CTRL_RESET;
   latch_if lif ();

   // Byte lanes of a table write: bit0 7:0, bit1 15:8, bit2 23:16
   function automatic logic [2:0] lane_sel(input logic high, input logic bsz, input logic ea0);
      logic [2:0] l;
      l = 3'h0;
      if (!high) begin
         l = bsz ? (ea0 ? 3'h2 : 3'h1) : 3'h3;
      end else begin
         l = (bsz && ea0) ? 3'h0 : 3'h4;
      end
      return l;
   endfunction

   function automatic logic [15:0] rd_pick(input logic high, input logic bsz, input logic ea0,
                                           input prog_word_t d);
      logic [15:0] r;
      r = 16'h0000;
      if (!high) begin
         r = bsz ? {8'h00, (ea0 ? d[15:8] : d[7:0])} : d[15:0];
      end else begin
         r = (bsz && ea0) ? 16'h0000 : {8'h00, d[23:16]};
      end
      return r;
   endfunction

   // APB answers one cycle into the access phase; stalled while busy
   assign wr_acc = psel && penable && pwrite && pready_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && penable && !busy_q && !pready_q;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         if (psel && penable && !busy_q && !pready_q) begin
            unique case (paddr)
               `FS_ADDR_CTRL: prdata_q <= {16'h0000, wr_q, erase_program_enable_q, err_q, 5'h00, op_q};
               `FS_ADDR_LOW: prdata_q <= {16'h0000, addr_low_q};
               `FS_ADDR_UPPER: prdata_q <= {24'h000000, addr_upper_q};
               `FS_ADDR_KEY: prdata_q <= 32'h0000_0000;
               `FS_ADDR_PAGE: prdata_q <= {24'h000000, page_q};
               default: pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   // Unlock: only a 0x55, 0xaa pair directly before the start write counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= KEY_LOCKED;
      end else if (wr_acc) begin
         if (paddr == `FS_ADDR_KEY) begin
            if (pwdata[7:0] == `FS_KEY_FIRST) begin
               key_q <= KEY_HALF;
            end else if (key_q == KEY_HALF && pwdata[7:0] == `FS_KEY_SECOND) begin
               key_q <= KEY_OPEN;
            end else begin
               key_q <= KEY_LOCKED;
            end
         end else begin
            key_q <= KEY_LOCKED;
         end
      end
   end

   // Start decision
   assign start_req = wr_acc && paddr == `FS_ADDR_CTRL && pwdata[`FS_CTRL_WR_BIT];
   assign op_ok = pwdata[`FS_CTRL_OP_MSB:0] == `FS_OP_ERASE_ROW || pwdata[`FS_CTRL_OP_MSB:0] == `FS_OP_PROG_BLOCK;
   assign start_ok = start_req && key_q == KEY_OPEN && pwdata[`FS_CTRL_ERASE_PROGRAM_ENABLE_BIT] && op_ok;
   assign op_last = busy_q && cnt_q == OP_CYCLES - 1;

   // Control register; a refused start sets the error flag, which beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= CTRL_RESET[`FS_CTRL_OP_MSB:0];
         erase_program_enable_q <= CTRL_RESET[`FS_CTRL_ERASE_PROGRAM_ENABLE_BIT];
         err_q <= CTRL_RESET[`FS_CTRL_ERR_BIT];
         wr_q <= CTRL_RESET[`FS_CTRL_WR_BIT];
      end else begin
         if (wr_acc && paddr == `FS_ADDR_CTRL) begin
            op_q <= pwdata[`FS_CTRL_OP_MSB:0];
            erase_program_enable_q <= pwdata[`FS_CTRL_ERASE_PROGRAM_ENABLE_BIT];
            err_q <= pwdata[`FS_CTRL_ERR_BIT] & err_q;
            wr_q <= start_ok;
         end
         if (start_req && !start_ok) begin
            err_q <= 1'b1;
         end
         if (op_last) begin
            wr_q <= 1'b0;
         end
      end
   end

   // Address registers: software writes, table instructions capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= 8'h00;
         addr_low_q <= 16'h0000;
         addr_upper_q <= 8'h00;
      end else begin
         if (wr_acc && paddr == `FS_ADDR_PAGE) begin
            page_q <= pwdata[7:0];
         end
         if (wr_acc && paddr == `FS_ADDR_LOW) begin
            addr_low_q <= pwdata[15:0];
         end
         if (wr_acc && paddr == `FS_ADDR_UPPER) begin
            addr_upper_q <= pwdata[7:0];
         end
         if (tbl_take) begin
            addr_low_q <= tbl_ea;
            addr_upper_q <= page_q;
         end
      end
   end

   // Operation timer; the core stays stalled for the whole count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
         cnt_q <= 32'h0000_0000;
         erase_q <= 1'b0;
         program_q <= 1'b0;
         op_addr_q <= 24'h000000;
      end else begin
         erase_q <= 1'b0;
         program_q <= 1'b0;
         if (start_ok) begin
            busy_q <= 1'b1;
            cnt_q <= 32'h0000_0000;
            if (pwdata[`FS_CTRL_OP_MSB:0] == `FS_OP_ERASE_ROW) begin
               erase_q <= 1'b1;
               op_addr_q <= {addr_upper_q, addr_low_q[15:`FS_ROW_ADDR_LSBS], `FS_ROW_ADDR_LSBS'(0)};
            end else begin
               program_q <= 1'b1;
               op_addr_q <= {addr_upper_q, addr_low_q[15:`FS_BLOCK_ADDR_LSBS], `FS_BLOCK_ADDR_LSBS'(0)};
            end
         end else if (op_last) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q + 32'h1;
         end
      end
   end

   assign cpu_stall = busy_q;
   assign flash_erase = erase_q;
   assign flash_program = program_q;
   assign flash_op_addr = op_addr_q;
   assign flash_prog_data = lif.words;

   // Table instructions: taken when idle, answered two cycles later
   assign tbl_take = tbl_req && !busy_q && tph_q == 2'h0;
   assign tbl_done = tph_q == 2'(`FS_TBL_CYCLES);
   assign tbl_rdata = tbl_rdata_q;
   assign flash_rd_addr = rd_addr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tph_q <= 2'h0;
         t_write_q <= 1'b0;
         t_high_q <= 1'b0;
         t_byte_q <= 1'b0;
         t_ea_q <= 16'h0000;
         rd_addr_q <= 24'h000000;
         tbl_rdata_q <= 16'h0000;
      end else begin
         if (tbl_take) begin
            tph_q <= 2'h1;
            t_write_q <= tbl_write;
            t_high_q <= tbl_high;
            t_byte_q <= tbl_byte;
            t_ea_q <= tbl_ea;
            rd_addr_q <= {page_q, tbl_ea[15:1], 1'b0};
         end else if (tph_q == 2'h1) begin
            tph_q <= 2'h2;
            if (!t_write_q) begin
               tbl_rdata_q <= rd_pick(t_high_q, t_byte_q, t_ea_q[0], flash_rd_data);
            end
         end else begin
            tph_q <= 2'h0;
         end
      end
   end

   // Table writes land in the latches only; the array is untouched
   assign lif.we = tbl_take && tbl_write;
   assign lif.idx = tbl_ea[2:1];
   assign lif.lanes = lane_sel(tbl_high, tbl_byte, tbl_ea[0]);
   assign lif.wdata = tbl_high ? {tbl_wdata[7:0], 16'h0000} : {8'h00, tbl_wdata};

   flash_write_latches u_latches (
      .pclk(pclk),
      .presetn(presetn),
      .lif(lif)
   );

   // Checks
   property p_addr_form;
      @(posedge pclk) disable iff (!presetn)
      tbl_take |=> rd_addr_q == {$past(page_q), $past(tbl_ea[15:1]), 1'b0};
   endproperty
   a_addr_form: assert property (p_addr_form) else $error("table address not page plus EA");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      tbl_take |=> addr_low_q == $past(tbl_ea) && addr_upper_q == $past(page_q);
   endproperty
   a_capture: assert property (p_capture) else $error("address registers missed table EA");

   property p_tbl_two;
      @(posedge pclk) disable iff (!presetn)
      tbl_take |-> !tbl_done ##1 !tbl_done ##1 tbl_done;
   endproperty
   a_tbl_two: assert property (p_tbl_two) else $error("table access not two cycles");

   property p_no_array_on_tbl;
      @(posedge pclk) disable iff (!presetn)
      lif.we |=> !flash_program && !flash_erase;
   endproperty
   a_no_array_on_tbl: assert property (p_no_array_on_tbl) else $error("table write hit array");

   property p_key_needed;
      @(posedge pclk) disable iff (!presetn)
      $rose(busy_q) |-> $past(key_q) == KEY_OPEN && $past(wr_acc);
   endproperty
   a_key_needed: assert property (p_key_needed) else $error("operation began without unlock");

   property p_bad_start;
      @(posedge pclk) disable iff (!presetn)
      start_req && !start_ok |=> !busy_q && !wr_q && err_q && !flash_erase && !flash_program;
   endproperty
   a_bad_start: assert property (p_bad_start) else $error("refused start disturbed flash");

   property p_relock;
      @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr != `FS_ADDR_KEY |=> key_q == KEY_LOCKED;
   endproperty
   a_relock: assert property (p_relock) else $error("key stayed open after other write");

   property p_stall;
      @(posedge pclk) disable iff (!presetn)
      busy_q |-> cpu_stall && wr_q && !pready;
   endproperty
   a_stall: assert property (p_stall) else $error("core not stalled during operation");

   property p_wr_clear;
      @(posedge pclk) disable iff (!presetn)
      op_last |=> !wr_q && !busy_q && cnt_q == OP_CYCLES - 1;
   endproperty
   a_wr_clear: assert property (p_wr_clear) else $error("start bit not cleared at end");

   property p_row_align;
      @(posedge pclk) disable iff (!presetn)
      flash_erase |-> flash_op_addr[`FS_ROW_ADDR_LSBS-1:0] == '0 && busy_q;
   endproperty
   a_row_align: assert property (p_row_align) else $error("erase not row aligned");

   c_erase: cover property (@(posedge pclk) disable iff (!presetn) flash_erase);
   c_program: cover property (@(posedge pclk) disable iff (!presetn) flash_program);
   c_refused: cover property (@(posedge pclk) disable iff (!presetn) start_req && !start_ok);
   c_done: cover property (@(posedge pclk) disable iff (!presetn) op_last);
endmodule

// file: pkg/flash_seq_defines.svh
// Purpose: Offsets, fields, codes and timing of the flash self-program sequencer
// Assumes: 8-bit APB byte address, 32-bit data, one register a word
// Notes: Times in their own unit; cycle counts derived from the clock rate
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// Register byte addresses
`define FS_ADDR_CTRL 8'h00
`define FS_ADDR_LOW 8'h04
`define FS_ADDR_UPPER 8'h08
`define FS_ADDR_KEY 8'h0c
`define FS_ADDR_PAGE 8'h10

// Control register fields and reset value
`define FS_CTRL_WR_BIT 15
`define FS_CTRL_ERASE_PROGRAM_ENABLE_BIT 14
`define FS_CTRL_ERR_BIT 13
`define FS_CTRL_OP_MSB 7
`define FS_CTRL_RESET 16'h0000
`define FS_OP_ERASE_ROW 8'h41
`define FS_OP_PROG_BLOCK 8'h01

// Unlock keys
`define FS_KEY_FIRST 8'h55
`define FS_KEY_SECOND 8'haa

// Geometry: a row is 32 instructions, 64 address units; a block is 4 instructions
`define FS_ROW_INSTR 32
`define FS_BLOCK_INSTR 4
`define FS_PANEL_ROWS 128
`define FS_ROW_ADDR_LSBS 6
`define FS_BLOCK_ADDR_LSBS 3

// Timing
`define FS_OP_TIME_US 2000
`define FS_CLK_KHZ 10000
`define FS_OP_CYCLES ((`FS_OP_TIME_US * `FS_CLK_KHZ) / 1000)
`define FS_TBL_CYCLES 2

`endif

// file: pkg/flash_seq_pkg.sv
// Purpose: Types shared by the sequencer and its write latches
// Assumes: 24-bit program words
// Notes: Constants live in flash_seq_defines.svh
package flash_seq_pkg;
   typedef logic [23:0] prog_word_t;
   typedef prog_word_t [3:0] latch_words_t;
   typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} key_state_e;
endpackage

// file: pkg/latch_if.sv
// Purpose: Carries latch writes from the sequencer to the write latch store
// Assumes: One write per cycle at most
// Notes: Byte lanes select bits 7:0, 15:8 and 23:16 of a program word
`timescale 1ns/1ps
interface latch_if;
   import flash_seq_pkg::*;
   logic we;
   logic [1:0] idx;
   logic [2:0] lanes;
   prog_word_t wdata;
   latch_words_t words;
   modport seq (output we, output idx, output lanes, output wdata, input words);
   modport store (input we, input idx, input lanes, input wdata, output words);
endinterface

// file: src/flash_write_latches.sv
// Purpose: Four-instruction panel write latches
// Assumes: Writes arrive through latch_if
// Notes: Contents survive a program operation until overwritten
`timescale 1ns/1ps
`include "flash_seq_defines.svh"
module flash_write_latches (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Latch port
   latch_if.store lif
);
   import flash_seq_pkg::*;

   latch_words_t words_q;

   for (genvar w = 0; w < `FS_BLOCK_INSTR; w++) begin : g_word
      for (genvar b = 0; b < 3; b++) begin : g_lane
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               words_q[w][b*8 +: 8] <= 8'h00;
            end else if (lif.we && lif.idx == 2'(w) && lif.lanes[b]) begin
               words_q[w][b*8 +: 8] <= lif.wdata[b*8 +: 8];
            end
         end
      end
   end

   assign lif.words = words_q;
endmodule

// file: verif/flash_array_model.sv
// Purpose: Behavioural flash array behind the sequencer
// Assumes: Two address units per instruction word
// Notes: Unwritten words read an address pattern, erased words all ones
`timescale 1ns/1ps
module flash_array_model (
   // Clock
   input wire logic pclk,
   // Read port
   input wire logic [23:0] flash_rd_addr,
   output logic [23:0] flash_rd_data,
   // Erase and program
   input wire logic flash_erase,
   input wire logic flash_program,
   input wire logic [23:0] flash_op_addr,
   input wire flash_seq_pkg::latch_words_t flash_prog_data
);
   import flash_seq_pkg::*;
   logic [23:0] mem [int];
   int upd = 0;
   always @(posedge pclk) begin
      if (flash_erase === 1'b1) begin
         for (int i = 0; i < 32; i++) mem[int'(flash_op_addr) + 2 * i] = 24'hffffff;
         upd++;
      end
      if (flash_program === 1'b1) begin
         for (int i = 0; i < 4; i++) mem[int'(flash_op_addr) + 2 * i] = flash_prog_data[i];
         upd++;
      end
   end
   // Re-evaluated on address change and on every array update
   always @(flash_rd_addr, upd) begin
      if (mem.exists(int'(flash_rd_addr))) flash_rd_data = mem[int'(flash_rd_addr)];
      else flash_rd_data = flash_rd_addr ^ 24'h5a5a5a;
   end
endmodule

// file: verif/test_flash_self_program_sequencer.sv
// Purpose: Self-checking bench of the flash self-program sequencer
// Assumes: OP_CYCLES shortened to 20
// Notes: Bench model keeps flash, latches and page in plain arrays
`timescale 1ns/1ps
`include "flash_seq_defines.svh"
module test_flash_self_program_sequencer;
   import flash_seq_pkg::*;
   localparam int unsigned OPC = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic tbl_req = 1'b0, tbl_write = 1'b0, tbl_high = 1'b0, tbl_byte = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, tbl_done, flash_erase, flash_program, cpu_stall;
   logic [15:0] tbl_ea = 16'h0, tbl_wdata = 16'h0, tbl_rdata, row, r;
   logic [23:0] flash_rd_addr, flash_rd_data, flash_op_addr, op_addr_seen, d;
   latch_words_t flash_prog_data, op_data_seen;
   int fails = 0, checks = 0, seed = 51, n_ops = 0, ops_m = 0, stall_run = 0, stall_len = 0;
   logic [1:0] op_kind;
   logic [23:0] mem_m [int];
   logic [23:0] lat_m [4];
   logic [7:0] page_m, b;
   always #50 pclk = ~pclk;
   flash_self_program_sequencer #(.OP_CYCLES(OPC)) flash_self_program_sequencer_i (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tbl_req, .tbl_write,
      .tbl_high, .tbl_byte, .tbl_ea, .tbl_wdata, .tbl_done, .tbl_rdata, .flash_rd_addr, .flash_rd_data,
      .flash_erase, .flash_program, .flash_op_addr, .flash_prog_data, .cpu_stall);
   flash_array_model flash_array_model_i (.pclk, .flash_rd_addr, .flash_rd_data, .flash_erase,
      .flash_program, .flash_op_addr, .flash_prog_data);
   always @(posedge pclk) begin
      if (cpu_stall === 1'b1) stall_run++;
      else if (stall_run != 0) begin
         stall_len = stall_run;
         stall_run = 0;
      end
      if (flash_erase === 1'b1 || flash_program === 1'b1) begin
         n_ops++;
         op_kind = {flash_erase, flash_program};
         op_addr_seen = flash_op_addr;
         op_data_seen = flash_prog_data;
      end
   end
   task automatic print_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [23:0] mrd(input logic [23:0] a);
      return mem_m.exists(int'(a)) ? mem_m[int'(a)] : (a ^ 24'h5a5a5a);
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         fails++;
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, dt, rd, er);
      chk({31'h0, er}, 32'h0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, e);
      chk({31'h0, er}, {31'h0, ee});
   endtask
   task automatic unlock();
      wr(`FS_ADDR_KEY, 32'h55);
      wr(`FS_ADDR_KEY, 32'haa);
   endtask
   task automatic tbl(input logic w, h, by, input logic [15:0] ea, dt, output logic [15:0] rv);
      int n;
      @(posedge pclk);
      tbl_req <= 1'b1;
      tbl_write <= w;
      tbl_high <= h;
      tbl_byte <= by;
      tbl_ea <= ea;
      tbl_wdata <= dt;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n == 2 && !w) chk(flash_rd_addr, {page_m, ea[15:1], 1'b0});
      end while (tbl_done !== 1'b1 && n < 50);
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
      chk(n, 3);
      rv = tbl_rdata;
      tbl_req <= 1'b0;
   endtask
   task automatic run_op(input logic [7:0] op, input logic [23:0] base);
      stall_len = 0;
      ops_m++;
      wr(`FS_ADDR_CTRL, {16'h0, 8'h40, op});
      unlock();
      wr(`FS_ADDR_CTRL, {16'h0, 8'hc0, op});
      repeat (2) @(posedge pclk); // Two idle slots after the start
      rdc(`FS_ADDR_CTRL, {16'h0, 8'h40, op}, 1'b0);
      repeat (2) @(posedge pclk);
      #1;
      chk(n_ops, ops_m);
      chk(op_kind, (op == `FS_OP_ERASE_ROW) ? 2'b10 : 2'b01);
      chk(stall_len, OPC);
      chk(op_addr_seen, base);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`FS_ADDR_CTRL, `FS_CTRL_RESET, 1'b0);
      wr(`FS_ADDR_KEY, 32'h55);
      rdc(`FS_ADDR_KEY, 32'h0, 1'b0);
      rdc(8'h14, 32'h0, 1'b1);
      page_m = 8'($random(seed));
      row = (16'($random(seed)) & 16'hff80) | 16'h0040;
      wr(`FS_ADDR_PAGE, {24'h0, page_m});
      tbl(1'b0, 1'b1, 1'b0, row + 16'h2, 16'h0, r);
      chk(r, mrd({page_m, row + 16'h2}) >> 16);
      rdc(`FS_ADDR_LOW, {16'h0, row + 16'h2}, 1'b0);
      rdc(`FS_ADDR_UPPER, {24'h0, page_m}, 1'b0);
      wr(`FS_ADDR_LOW, {16'h0, row});
      wr(`FS_ADDR_UPPER, {24'h0, page_m});
      for (int i = 0; i < 32; i++) mem_m[int'({page_m, row}) + 2 * i] = 24'hffffff;
      run_op(`FS_OP_ERASE_ROW, {page_m, row});
      for (int p = 0; p < 8; p++) begin
         for (int i = 0; i < 4; i++) begin // In order from latch 0, one aligned group
            d = 24'($random(seed));
            tbl(1'b1, 1'b0, 1'b0, row + 16'(p * 8 + i * 2), d[15:0], r);
            tbl(1'b1, 1'b1, 1'b0, row + 16'(p * 8 + i * 2), {8'($random(seed)), d[23:16]}, r);
            lat_m[i] = d;
         end
         for (int i = 0; i < 4; i++) chk(flash_prog_data[i], lat_m[i]);
         for (int i = 0; i < 4; i++) mem_m[int'({page_m, row}) + p * 8 + 2 * i] = lat_m[i];
         run_op(`FS_OP_PROG_BLOCK, {page_m, row + 16'(p * 8)});
         for (int i = 0; i < 4; i++) chk(op_data_seen[i], lat_m[i]);
      end
      // One word either side of the row shows the erase stayed inside it
      for (int i = -1; i < 33; i++) begin
         tbl(1'b0, 1'b0, 1'b0, row + 16'(2 * i), 16'h0, r);
         chk(r, mrd({page_m, row + 16'(2 * i)}) & 24'hffff);
         tbl(1'b0, 1'b1, 1'b0, row + 16'(2 * i), 16'h0, r);
         chk(r, mrd({page_m, row + 16'(2 * i)}) >> 16);
      end
      tbl(1'b0, 1'b0, 1'b1, row + 16'h1, 16'h0, r);
      chk(r, (mrd({page_m, row}) >> 8) & 24'hff);
      tbl(1'b0, 1'b1, 1'b1, row, 16'h0, r);
      chk(r, mrd({page_m, row}) >> 16);
      b = 8'($random(seed));
      tbl(1'b1, 1'b0, 1'b1, row + 16'h1, {b, b}, r);
      lat_m[0][15:8] = b;
      chk(flash_prog_data[0], lat_m[0]);
      wr(`FS_ADDR_CTRL, 32'hc041);
      rdc(`FS_ADDR_CTRL, 32'h6041, 1'b0);
      wr(`FS_ADDR_CTRL, 32'h4041);
      unlock();
      wr(`FS_ADDR_LOW, {16'h0, row});
      wr(`FS_ADDR_CTRL, 32'hc041);
      rdc(`FS_ADDR_CTRL, 32'h6041, 1'b0);
      wr(`FS_ADDR_CTRL, 32'h4041);
      wr(`FS_ADDR_KEY, 32'h55);
      wr(`FS_ADDR_KEY, 32'h77);
      wr(`FS_ADDR_KEY, 32'haa);
      wr(`FS_ADDR_CTRL, 32'hc041);
      rdc(`FS_ADDR_CTRL, 32'h6041, 1'b0);
      wr(`FS_ADDR_CTRL, 32'h0041);
      unlock();
      wr(`FS_ADDR_CTRL, 32'h8041);
      rdc(`FS_ADDR_CTRL, 32'h2041, 1'b0);
      repeat (2) @(posedge pclk);
      #1;
      chk(n_ops, ops_m);
      print_verdict();
   end
endmodule
